// ===== core/lfbd_dev.sv
`timescale 1ns/1ns
`default_nettype none
module lfbd_dev
  import lfbd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca,
  input wire logic [3:0] dm,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic dq_oe,
  input wire logic [3:0] dqs_in,
  output logic [3:0] dqs_out,
  output logic [3:0] dqs_c_out,
  output logic dqs_oe,
  output logic [1:0] pwr_mode,
  output logic dai_busy,
  output logic [3:0] bank_off,
  output logic [7:0] seg_off
);
  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  lfbd_pins_t pin_in;
  lfbd_pins_t s1;
  lfbd_pins_t s2;
  lfbd_pins_t s3;
  lfbd_pins_t filt;
  lfbd_pins_t next_filt;

  assign pin_in = {ck, cke, cs_n, ca, dm, dq_in, dqs_in};

  // a bit moves only once stages two and three agree
  always_comb begin
    next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] mem [MEM_WORDS];
  logic wr_go;
  logic [3:0][AW-1:0] wr_idx;
  logic [3:0][31:0] wr_dat;
  logic [3:0][3:0] wr_msk;

  always_ff @(posedge clk) begin
    if (wr_go) begin
      for (int w = 0; w < 4; w++) begin
        for (int b = 0; b < 4; b++) begin
          if (!wr_msk[w][b]) begin
            mem[wr_idx[w]][8*b +: 8] <= wr_dat[w][8*b +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command, burst and mode control
  // ----------------------------------------------------------------
  lfbd_ctl_t st;
  lfbd_ctl_t nx;
  logic ck_rise;
  logic ck_fall;
  logic dqs_edge;
  logic [7:0] ma;
  logic [7:0] op;
  logic [BA_W-1:0] cbank;
  logic [7:0] mr_val;

  assign ck_rise = filt.ck & ~st.ck_d;
  assign ck_fall = ~filt.ck & st.ck_d;
  // byte 0 strobe times all four lanes
  assign dqs_edge = filt.dqs[0] ^ st.dqs_d;
  assign ma = {filt.ca[1:0], st.ca_r[9:4]};
  assign op = filt.ca[9:2];
  assign cbank = st.ca_r[8:7];
  assign mr_val = (ma == MA_DAI) ? {7'h00, st.dai} :
                  (ma == MA_BURST) ? st.mr1 :
                  (ma == MA_LAT) ? st.mr2 :
                  (ma == MA_BMASK) ? st.mr16 :
                  (ma == MA_SMASK) ? st.mr17 : 8'h00;

  // word index of burst beat b, wrapping inside the burst
  function automatic logic [AW-1:0] beat_idx(input lfbd_ctl_t c, input logic [4:0] b);
    logic [COL_W-1:0] msk;
    logic [COL_W-1:0] off;
    msk = {5'h00, c.blm};
    off = c.ilv ? (c.col ^ {4'h0, b}) : (c.col + {4'h0, b});
    return {c.bank, c.row[c.bank], (c.col & ~msk) | (off & msk)};
  endfunction

  function automatic lfbd_ctl_t dev_reset(input lfbd_ctl_t c);
    lfbd_ctl_t r;
    r = c;
    r.mr1 = MR1_RST;
    r.mr2 = MR2_RST;
    r.mr16 = 8'h00;
    r.mr17 = 8'h00;
    r.opn = 4'h0;
    r.bst = BS_IDLE;
    r.dq_oe = 1'b0;
    r.dqs_oe = 1'b0;
    r.dai = 1'b1;
    r.dai_cnt = DAI_CNT0;
    return r;
  endfunction

  always_comb begin
    nx = st;
    wr_go = 1'b0;
    wr_idx = '0;
    wr_dat = '0;
    wr_msk = '0;
    nx.ck_d = filt.ck;
    nx.dqs_d = filt.dqs[0];
    if (st.dai_cnt != 8'h00) begin
      nx.dai_cnt = st.dai_cnt - 8'h01;
      if (st.dai_cnt == 8'h01) begin
        nx.dai = 1'b0;
      end
    end
    // rising half: chip select and CKE belong here only
    if (ck_rise) begin
      nx.ca_r = filt.ca;
      nx.cke_r = filt.cke;
      nx.live = st.cke_r & filt.cke & ~filt.cs_n & (st.pwr == PW_ON);
      if (st.pwr == PW_ON && st.cke_r && !filt.cke) begin
        if (!filt.cs_n && filt.ca[3:0] == C_REFAB) begin
          nx.pwr = PW_SREF;
        end else if (!filt.cs_n && filt.ca[3:0] == C_BST) begin
          nx.pwr = PW_DPD;
        end else begin
          nx.pwr = PW_PDN;
        end
      end else if (st.pwr != PW_ON && filt.cke) begin
        nx.pwr = PW_ON;
        if (st.pwr == PW_DPD) begin
          nx = dev_reset(nx);
        end
      end
      if (st.bst == BS_LAT) begin
        nx.lat_cnt = st.lat_cnt + 4'h1;
        if (nx.lat_cnt == st.lat) begin
          nx.bst = BS_DATA;
        end
      end
    end
    // falling half completes the command
    if (ck_fall && st.live) begin
      if (st.ca_r[1:0] == C_ACT) begin
        nx.opn[cbank] = 1'b1;
        nx.row[cbank] = {st.ca_r[6:2], filt.ca[9:2]};
      end else if (st.bst == BS_IDLE && st.opn[cbank] &&
                   (st.ca_r[2:0] == C_RD || st.ca_r[2:0] == C_WR)) begin
        // a closed bank ignores the access
        nx.bst = BS_LAT;
        nx.lat_cnt = 4'h0;
        nx.rd = st.ca_r[2];
        nx.mrr = 1'b0;
        nx.ap = filt.ca[0];
        nx.bank = cbank;
        nx.col = {filt.ca[6:1], st.ca_r[6:5], 1'b0};
        nx.blm = bl_mask(st.mr1[2:0]);
        nx.ilv = st.mr1[ILV_POS];
        nx.beat = 5'h00;
        nx.lat = st.ca_r[2] ? rl_of(st.mr2[3:0]) : wl_of(st.mr2[3:0]);
        if (st.ca_r[2]) begin
          for (int i = 0; i < 4; i++) begin
            nx.pre[i] = mem[beat_idx(nx, 5'(i))];
          end
        end
      end else if (st.bst == BS_IDLE && st.ca_r[3:0] == C_MRR) begin
        nx.bst = BS_LAT;
        nx.lat_cnt = 4'h0;
        nx.rd = 1'b1;
        nx.mrr = 1'b1;
        nx.ap = 1'b0;
        nx.blm = 4'h3;
        nx.beat = 5'h00;
        nx.lat = rl_of(st.mr2[3:0]);
        nx.pre = {4{24'h000000, mr_val}};
      end else if (st.ca_r[3:0] == C_MRW) begin
        if (ma == MA_RESET) begin
          nx = dev_reset(nx);
        end else if (ma == MA_BURST) begin
          nx.mr1 = op;
        end else if (ma == MA_LAT) begin
          nx.mr2 = op;
        end else if (ma == MA_BMASK) begin
          nx.mr16 = op;
        end else if (ma == MA_SMASK) begin
          nx.mr17 = op;
        end
      end else if (st.ca_r[3:0] == C_PRE) begin
        if (st.ca_r[4]) begin
          nx.opn = 4'h0;
        end else begin
          nx.opn[cbank] = 1'b0;
        end
      end
    end
    // read beats leave on every link clock edge
    if (nx.bst == BS_DATA && st.rd && (ck_rise || ck_fall)) begin
      if ({1'b0, st.blm} < st.beat) begin
        nx.bst = BS_IDLE;
        nx.dq_oe = 1'b0;
        nx.dqs_oe = 1'b0;
        if (st.ap) begin
          nx.opn[st.bank] = 1'b0;
        end
      end else begin
        nx.dq_o = st.pre[st.beat[1:0]];
        nx.dqs_o = {4{~st.beat[0]}};
        nx.dqs_c = {4{st.beat[0]}};
        nx.dq_oe = 1'b1;
        nx.dqs_oe = 1'b1;
        nx.beat = st.beat + 5'h01;
        if (st.beat[1:0] == 2'h3 && !st.mrr) begin
          for (int i = 0; i < 4; i++) begin
            nx.pre[i] = mem[beat_idx(st, 5'(st.beat + 5'h01 + 5'(i)))];
          end
        end
      end
    end
    // write beats land on strobe edges, four per core write
    if (st.bst == BS_DATA && !st.rd && dqs_edge) begin
      nx.wb[st.beat[1:0]] = filt.dq;
      nx.wm[st.beat[1:0]] = filt.dm;
      nx.beat = st.beat + 5'h01;
      if (st.beat[1:0] == 2'h3) begin
        wr_go = 1'b1;
        for (int i = 0; i < 4; i++) begin
          wr_idx[i] = beat_idx(st, 5'({st.beat[4:2], 2'h0} + 5'(i)));
          wr_dat[i] = nx.wb[i];
          wr_msk[i] = nx.wm[i];
        end
      end
      if (st.beat[3:0] == st.blm) begin
        nx.bst = BS_IDLE;
        if (st.ap) begin
          nx.opn[st.bank] = 1'b0;
        end
      end
    end
    // drivers and bursts stop while CKE is low
    if (nx.pwr != PW_ON) begin
      nx.bst = BS_IDLE;
      nx.dq_oe = 1'b0;
      nx.dqs_oe = 1'b0;
    end
    nx.bank_off = (nx.pwr == PW_SREF) ? nx.mr16[3:0] : 4'h0;
    nx.seg_off = (nx.pwr == PW_SREF) ? nx.mr17 : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      st.mr1 <= MR1_RST;
      st.mr2 <= MR2_RST;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from st
  // ----------------------------------------------------------------
  assign dq_out = st.dq_o;
  assign dq_oe = st.dq_oe;
  assign dqs_out = st.dqs_o;
  assign dqs_c_out = st.dqs_c;
  assign dqs_oe = st.dqs_oe;
  assign pwr_mode = st.pwr;
  assign dai_busy = st.dai;
  assign bank_off = st.bank_off;
  assign seg_off = st.seg_off;
endmodule
`default_nettype wire

// ===== core/lfbd_pkg.sv
package lfbd_pkg;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int BA_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int AW = BA_W + ROW_W + COL_W;
  localparam int MEM_WORDS = 1 << AW;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int T_DAI_NS = 10000;
  // longest time, so round down
  localparam int DAI_CYC = T_DAI_NS / CLK_NS;
  localparam logic [7:0] DAI_CNT0 = 8'(DAI_CYC);
  // ----------------------------------------------------------------
  // command codes on rising-edge CA
  // ----------------------------------------------------------------
  localparam logic [3:0] C_MRW = 4'h0;
  localparam logic [3:0] C_MRR = 4'h8;
  localparam logic [3:0] C_REFAB = 4'hC;
  localparam logic [3:0] C_BST = 4'h3;
  localparam logic [3:0] C_PRE = 4'hB;
  localparam logic [1:0] C_ACT = 2'h2;
  localparam logic [2:0] C_WR = 3'h1;
  localparam logic [2:0] C_RD = 3'h5;
  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  localparam logic [7:0] MA_DAI = 8'h00;
  localparam logic [7:0] MA_BURST = 8'h01;
  localparam logic [7:0] MA_LAT = 8'h02;
  localparam logic [7:0] MA_ZQ = 8'h0A;
  localparam logic [7:0] MA_BMASK = 8'h10;
  localparam logic [7:0] MA_SMASK = 8'h11;
  localparam logic [7:0] MA_RESET = 8'h3F;
  localparam logic [7:0] MR1_RST = 8'h02;
  localparam logic [7:0] MR2_RST = 8'h01;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] BL16 = 3'h4;
  localparam int ILV_POS = 3;

  typedef enum logic [1:0] {
    PW_ON = 2'h0, PW_PDN = 2'h1, PW_SREF = 2'h3, PW_DPD = 2'h2
  } lfbd_pwr_t;
  typedef enum logic [1:0] {
    BS_IDLE = 2'h0, BS_LAT = 2'h1, BS_DATA = 2'h3
  } lfbd_bst_t;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic [9:0] ca;
    logic [3:0] dm;
    logic [31:0] dq;
    logic [3:0] dqs;
  } lfbd_pins_t;

  typedef struct packed {
    lfbd_pwr_t pwr;
    lfbd_bst_t bst;
    logic rd;
    logic mrr;
    logic ap;
    logic ilv;
    logic ck_d;
    logic dqs_d;
    logic cke_r;
    logic live;
    logic [9:0] ca_r;
    logic [3:0] lat_cnt;
    logic [3:0] lat;
    logic [4:0] beat;
    logic [3:0] blm;
    logic [BA_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [3:0] opn;
    logic [3:0][ROW_W-1:0] row;
    logic [7:0] mr1;
    logic [7:0] mr2;
    logic [7:0] mr16;
    logic [7:0] mr17;
    logic dai;
    logic [7:0] dai_cnt;
    logic [3:0][31:0] pre;
    logic [3:0][31:0] wb;
    logic [3:0][3:0] wm;
    logic [31:0] dq_o;
    logic dq_oe;
    logic [3:0] dqs_o;
    logic [3:0] dqs_c;
    logic dqs_oe;
    logic [3:0] bank_off;
    logic [7:0] seg_off;
  } lfbd_ctl_t;

  function automatic logic [3:0] bl_mask(input logic [2:0] code);
    return (code == BL16) ? 4'hF : (code == BL8) ? 4'h7 : 4'h3;
  endfunction

  function automatic logic [3:0] rl_of(input logic [3:0] code);
    return (code >= 4'h1 && code <= 4'h6) ? code + 4'h2 : 4'h3;
  endfunction

  function automatic logic [3:0] wl_of(input logic [3:0] code);
    case (code)
      4'h2, 4'h3: return 4'h2;
      4'h4: return 4'h3;
      4'h5, 4'h6: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction
endpackage

// ===== tb/lfbd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module lfbd_checker
  import lfbd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic dq_oe,
  input wire logic [3:0] dqs_out,
  input wire logic [3:0] dqs_c_out,
  input wire logic dqs_oe,
  input wire logic [1:0] pwr_mode,
  input wire logic dai_busy,
  input wire logic [3:0] bank_off,
  input wire logic [7:0] seg_off
);
  int busy_len;
  int next_busy_len;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  always_comb begin
    next_busy_len = dai_busy ? busy_len + 1 : 0;
  end
  always_ff @(posedge clk) begin
    busy_len <= next_busy_len;
  end
  oe_pair_a: assert property (dqs_oe == dq_oe)
    else $error("strobe and data enables differ");
  strobe_comp_a: assert property (dqs_oe |-> dqs_c_out == ~dqs_out)
    else $error("strobe pair not complementary");
  lane_same_a: assert property (dqs_oe |-> dqs_out == 4'h0 || dqs_out == 4'hF)
    else $error("byte strobes disagree");
  first_beat_a: assert property ($rose(dq_oe) |-> dqs_out == 4'hF)
    else $error("first read beat not on strobe high");
  beat_stand_a: assert property (dq_oe && $changed(dqs_out) |=> $stable(dqs_out) [*2])
    else $error("read beat too short");
  pd_entry_a: assert property ($fell(cke) |-> ##[1:24] pwr_mode != PW_ON)
    else $error("no low power entry");
  pd_exit_a: assert property ($rose(cke) && pwr_mode != PW_ON |-> ##[1:24] pwr_mode == PW_ON)
    else $error("no low power exit");
  sleep_quiet_a: assert property (pwr_mode != PW_ON |-> !dq_oe)
    else $error("drivers on while asleep");
  mask_idle_a: assert property (pwr_mode != PW_SREF |-> bank_off == 4'h0 && seg_off == 8'h00)
    else $error("array masks shown outside self refresh");
  dai_len_a: assert property (busy_len <= DAI_CYC)
    else $error("auto init busy too long");
endmodule
`default_nettype wire

// ===== tb/lfbd_host.sv
`timescale 1ns/1ns
`default_nettype none
module lfbd_host
  import lfbd_pkg::*;
(
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic [9:0] ca,
  output logic [3:0] dm,
  output logic [31:0] dq,
  output logic [3:0] dqs
);
  logic nx;
  // link clock runs free, phase unrelated to clk
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    nx = 1'b1;
    cs_n = 1'b1;
    ca = 10'h155;
    dm = 4'h0;
    dq = 32'h0;
    dqs = 4'h0;
    #13;
    forever #160 ck = ~ck;
  end
  // rise half, then fall half, one cycle only
  task automatic cmd(input logic [9:0] rh, input logic [9:0] fh);
    @(negedge ck);
    #80 cs_n = 1'b0;
    cke = nx;
    ca = rh;
    @(posedge ck);
    #80 ca = fh;
    @(negedge ck);
    #80 cs_n = 1'b1;
    ca = ~fh;
  endtask
  task automatic mrw(input logic [7:0] a, input logic [7:0] op);
    cmd({a[5:0], C_MRW}, {op, a[7:6]});
  endtask
  task automatic ckel(input logic v);
    @(negedge ck);
    #80 cke = v;
    nx = v;
  endtask
  // strobe edge sits mid-beat
  task automatic burst(input int wl, input int bl, input logic [31:0] wd[16],
                       input logic [3:0] wm[16]);
    repeat (wl) @(posedge ck);
    for (int i = 0; i < bl; i++) begin
      dq = wd[i];
      dm = wm[i];
      #80 dqs = {4{~dqs[0]}};
      if (i[0])
        @(posedge ck);
      else
        @(negedge ck);
    end
    dq = ~dq;
  endtask
  task automatic init();
    #100;
    repeat (5) @(posedge ck);
    ckel(1'b1);
    #200000;
    mrw(MA_RESET, 8'h00);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lfbd_pkg::*;
  logic clk, rstn, ck, cke, cs_n, dq_oe, dqs_oe, dai_busy, prv_oe, prv_s, ilv;
  logic [9:0] ca;
  logic [3:0] dm, dqs_in, dqs_out, dqs_c_out, bank_off, h_dqs;
  logic [31:0] dq_in, dq_out, h_dq;
  logic [1:0] pwr_mode, b;
  logic [7:0] seg_off;
  logic [12:0] r;
  logic [8:0] col;
  logic [31:0] got[$];
  logic [31:0] mem[int];
  logic [31:0] d[16];
  logic [3:0] m[16];
  int n_fail, compares, rises, lat;
  logic [7:0] bl_t[4] = '{8'h02, 8'h03, 8'h0B, 8'h04};
  logic [7:0] lat_t[4] = '{8'h01, 8'h04, 8'h06, 8'h06};
  int bl_n[4] = '{4, 8, 8, 16};
  int rl_n[4] = '{3, 6, 8, 8};
  int wl_n[4] = '{1, 3, 4, 4};
  // shared wires: device wins while it drives
  assign dq_in = dq_oe ? dq_out : h_dq;
  assign dqs_in = dqs_oe ? dqs_out : h_dqs;
  lfbd_dev lfbd_dev_inst (.clk(clk), .rstn(rstn), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca),
    .dm(dm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in),
    .dqs_out(dqs_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe), .pwr_mode(pwr_mode),
    .dai_busy(dai_busy), .bank_off(bank_off), .seg_off(seg_off));
  lfbd_host lfbd_host_inst (.ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca), .dm(dm), .dq(h_dq),
    .dqs(h_dqs));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge ck) rises <= rises + 1;
  // a new beat shows as a strobe toggle
  always @(negedge clk) begin
    if (dq_oe === 1'b1 && (!prv_oe || dqs_out[0] !== prv_s))
      got.push_back(dq_out);
    if (dq_oe === 1'b1 && !prv_oe)
      lat = rises;
    prv_oe = (dq_oe === 1'b1);
    prv_s = dqs_out[0];
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rw(input logic [2:0] c);
    lfbd_host_inst.cmd({1'b0, b, col[2:1], 2'h0, c}, {3'h0, col[8:3], 1'b0});
  endtask
  function automatic int loc(int j, int bl);
    int o;
    o = ilv ? ((col % bl) ^ j) : ((col + j) % bl);
    return (b << 22) | (r << 9) | (col - col % bl + o);
  endfunction
  task automatic settle();
    for (int t = 0; t < 400 && dq_oe !== 1'b0; t++)
      @(negedge clk);
    repeat (20) @(negedge clk);
  endtask
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    {n_fail, compares, rises, lat} = '0;
    {prv_oe, prv_s, ilv, b} = '0;
    void'($urandom(69));
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    lfbd_host_inst.init();
    repeat (10) @(negedge clk);
    chk(dai_busy, 1'b1);
    for (int t = 0; t < 300 && dai_busy !== 1'b0; t++)
      @(negedge clk);
    chk(dai_busy, 1'b0);
    lfbd_host_inst.mrw(MA_ZQ, 8'hFF);
    col = 9'h0;
    rw(C_RD); // closed bank, must stay silent
    repeat (80) @(negedge clk);
    chk(got.size(), 0);
    for (int i = 0; i < 4; i++) begin
      lfbd_host_inst.mrw(MA_BURST, bl_t[i]);
      lfbd_host_inst.mrw(MA_LAT, lat_t[i]);
      ilv = bl_t[i][3];
      b = 2'($urandom);
      r = 13'($urandom);
      col = 9'($urandom) & 9'h1FE;
      lfbd_host_inst.cmd({1'b0, b, r[12:8], C_ACT}, {r[7:0], 2'h0});
      for (int k = 0; k < 2; k++) begin
        for (int j = 0; j < 16; j++) begin
          d[j] = $urandom;
          m[j] = k ? 4'($urandom) : 4'h0;
        end
        rw(C_WR);
        lfbd_host_inst.burst(wl_n[i], bl_n[i], d, m);
        for (int j = 0; j < bl_n[i]; j++)
          for (int y = 0; y < 4; y++)
            if (!m[j][y])
              mem[loc(j, bl_n[i])][8*y +: 8] = d[j][8*y +: 8];
        settle();
      end
      got.delete();
      rw(C_RD);
      rises = 0;
      for (int t = 0; t < 400 && got.size() < bl_n[i]; t++)
        @(negedge clk);
      settle();
      chk(lat, rl_n[i]);
      chk(got.size(), bl_n[i]);
      for (int j = 0; j < bl_n[i] && j < got.size(); j++)
        chk(got[j], mem[loc(j, bl_n[i])]);
    end
    // mode register read returns the last burst setting in byte 0 of every beat, upper bytes zero
    got.delete();
    lfbd_host_inst.cmd({MA_BURST[5:0], C_MRR}, {8'h00, MA_BURST[7:6]});
    rises = 0;
    for (int t = 0; t < 400 && got.size() < 4; t++)
      @(negedge clk);
    settle();
    chk(lat, rl_n[3]);
    chk(got.size(), 4);
    for (int j = 0; j < 4 && j < got.size(); j++)
      chk(got[j], {24'h000000, bl_t[3]});
    // precharge all closes the open bank, so a read must stay silent
    lfbd_host_inst.cmd({5'h00, 1'b1, C_PRE}, 10'h000);
    got.delete();
    rw(C_RD);
    repeat (80) @(negedge clk);
    chk(got.size(), 0);
    lfbd_host_inst.mrw(MA_BMASK, 8'h05);
    lfbd_host_inst.mrw(MA_SMASK, 8'hA5);
    lfbd_host_inst.ckel(1'b0);
    repeat (20) @(negedge clk);
    chk(pwr_mode, PW_PDN);
    lfbd_host_inst.ckel(1'b1);
    repeat (20) @(negedge clk);
    chk(pwr_mode, PW_ON);
    lfbd_host_inst.nx = 1'b0;
    lfbd_host_inst.cmd({6'h0, C_REFAB}, 10'h0);
    repeat (20) @(negedge clk);
    chk({pwr_mode, bank_off, seg_off}, {PW_SREF, 4'h5, 8'hA5});
    lfbd_host_inst.ckel(1'b1);
    repeat (20) @(negedge clk);
    chk({pwr_mode, bank_off, seg_off}, {PW_ON, 12'h000});
    // deep power-down entry, then exit restarts auto-init
    lfbd_host_inst.nx = 1'b0;
    lfbd_host_inst.cmd({6'h00, C_BST}, 10'h000);
    repeat (20) @(negedge clk);
    chk(pwr_mode, PW_DPD);
    lfbd_host_inst.ckel(1'b1);
    repeat (20) @(negedge clk);
    chk({pwr_mode, dai_busy}, {PW_ON, 1'b1});
    complete_run();
  end
endmodule
bind lfbd_dev lfbd_checker lfbd_checker_inst (.clk(clk), .rstn(rstn), .cke(cke),
  .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe),
  .pwr_mode(pwr_mode), .dai_busy(dai_busy), .bank_off(bank_off), .seg_off(seg_off));
`default_nettype wire
